/* File: rtl/anmr_pkg.sv */
// types shared by the next page management register bank
package anmr_pkg;
  typedef enum logic [1:0] {
    MdPreamble,
    MdHeader,
    MdTurn,
    MdData
  } anmr_md_state_e;
  typedef logic [15:0] anmr_word_t;
endpackage

/* File: rtl/anmr_regs.sv */
// management register bank: next page, extended status, autoneg interrupt
`timescale 1ns/1ps
`include "anmr_regs_map.svh"
module anmr_regs
  import anmr_pkg::*;
#(
  parameter bit AUTONEG = 1'b1
)(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] phyAddr,
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic [15:0] controlValue,
  input wire logic [15:0] statusValue,
  output logic controlWrite,
  output logic [15:0] controlWrData,
  input wire logic anComplete,
  input wire logic rxPageValid,
  input wire logic [15:0] rxPage,
  input wire logic txPageSent,
  output logic [15:0] txPage,
  output logic autoneg_done_irq
);
  anmr_md_state_e state_q;
  logic mdcPrev_q;
  logic [5:0] preCnt_q;
  logic [4:0] bitCnt_q;
  logic [15:0] shift_q;
  logic [15:0] rdShift_q;
  logic isRead_q;
  logic hit_q;
  logic [4:0] regAddr_q;
  logic mdioOut_q;
  logic mdioOe_q;
  anmr_word_t txPage_q;
  anmr_word_t rxPage_q;
  logic pageRcvd_q;
  logic intEn_q;
  logic intStatus_q;
  logic controlWrite_q;
  logic [15:0] controlWrData_q;
  function automatic logic anmr_implemented(input logic [4:0] a);
    logic base, an;
    base = (a == `ANMR_OFS_CONTROL) || (a == `ANMR_OFS_STATUS) ||
           (a == `ANMR_OFS_ID_HI) || (a == `ANMR_OFS_ID_LO) ||
           (a == `ANMR_OFS_EXT_STATUS);
    an = (a == `ANMR_OFS_EXPANSION) || (a == `ANMR_OFS_NP_TX) ||
         (a == `ANMR_OFS_NP_RX) || (a == `ANMR_OFS_AN_IRQ);
    return base || (AUTONEG && an);
  endfunction
  wire mdcRise = mdc && !mdcPrev_q;
  wire [15:0] hdrNext = {shift_q[14:0], mdioIn};
  wire [4:0] hdrReg = hdrNext[4:0];
  wire hdrStartOk = hdrNext[12] == 1'b1;
  wire hdrRead = hdrNext[11:10] == 2'b10;
  wire hdrWrite = hdrNext[11:10] == 2'b01;
  wire hdrMatch = hdrNext[9:5] == phyAddr;
  wire hdrDone = mdcRise && (state_q == MdHeader) &&
                 (bitCnt_q == `ANMR_HDR_BITS - 5'h01);
  wire frameOk = hdrStartOk && hdrMatch && (hdrRead || hdrWrite);
  wire rdCommit = hdrDone && frameOk && hdrRead;
  wire dataDone = mdcRise && (state_q == MdData) &&
                  (bitCnt_q == `ANMR_DATA_BITS - 5'h01);
  wire wrCommit = dataDone && hit_q && !isRead_q;
  wire [15:0] wrData = hdrNext;
  wire wrTx = wrCommit && anmr_implemented(regAddr_q) &&
              (regAddr_q == `ANMR_OFS_NP_TX);
  wire wrIrq = wrCommit && anmr_implemented(regAddr_q) &&
               (regAddr_q == `ANMR_OFS_AN_IRQ);
  wire wrCtl = wrCommit && (regAddr_q == `ANMR_OFS_CONTROL);
  wire rdExp = rdCommit && anmr_implemented(hdrReg) &&
               (hdrReg == `ANMR_OFS_EXPANSION);
  function automatic anmr_word_t anmr_read(input logic [4:0] a);
    anmr_word_t v;
    v = 16'h0000;
    if (anmr_implemented(a))
    begin
      case (a)
        `ANMR_OFS_CONTROL: v = controlValue;
        `ANMR_OFS_STATUS: v = statusValue;
        `ANMR_OFS_EXPANSION:
        begin
          v[`ANMR_EXP_NP_ABLE_BIT] = 1'b1;
          v[`ANMR_EXP_PAGE_RCVD_BIT] = pageRcvd_q;
        end
        `ANMR_OFS_NP_TX: v = txPage_q;
        `ANMR_OFS_NP_RX: v = rxPage_q;
        `ANMR_OFS_EXT_STATUS: v = `ANMR_EXT_STATUS_VALUE;
        `ANMR_OFS_AN_IRQ:
        begin
          v[`ANMR_IRQ_STATUS_BIT] = intStatus_q;
          v[`ANMR_IRQ_ENABLE_BIT] = intEn_q;
        end
        default: v = 16'h0000;
      endcase
    end
    return v;
  endfunction
  // transmit page: bit 14 forced 0, toggle owned by hardware
  wire [15:0] txWrVal = {wrData[15], 1'b0, wrData[13:12],
                         txPage_q[`ANMR_NP_TOGGLE_BIT], wrData[10:0]};
  wire [15:0] txTogVal = {txPage_q[15:12], !txPage_q[`ANMR_NP_TOGGLE_BIT],
                          txPage_q[10:0]};
  wire [15:0] txPage_d = wrTx ? txWrVal : txPage_q;
  wire [15:0] txPageT_d = txPageSent ?
    {txPage_d[15:12], txTogVal[11], txPage_d[10:0]} : txPage_d;
  wire [15:0] rxPage_d = {rxPage[15], 1'b1, rxPage[13:0]};
  wire intEn_d = wrIrq ? wrData[`ANMR_IRQ_ENABLE_BIT] : intEn_q;
  wire intKeep = wrIrq ? wrData[`ANMR_IRQ_STATUS_BIT] : intStatus_q;
  wire anDone = AUTONEG && anComplete;
  wire intStatus_d = intEn_d && (anDone || intKeep);
  wire pageRcvd_d = rxPageValid || (pageRcvd_q && !rdExp);
  // management frame receiver, pins sampled on mdc rising edges
  always_ff @(posedge core_clk)
  begin
    mdcPrev_q <= mdc;
    if (rst)
    begin
      state_q <= MdPreamble;
      preCnt_q <= 6'h00;
      bitCnt_q <= 5'h00;
      shift_q <= 16'h0000;
      rdShift_q <= 16'h0000;
      isRead_q <= 1'b0;
      hit_q <= 1'b0;
      regAddr_q <= 5'h00;
      mdioOut_q <= 1'b1;
      mdioOe_q <= 1'b0;
    end
    else if (mdcRise)
    begin
      shift_q <= hdrNext;
      bitCnt_q <= bitCnt_q + 5'h01;
      case (state_q)
        MdPreamble:
        begin
          bitCnt_q <= 5'h00;
          if (mdioIn)
            preCnt_q <= (preCnt_q == `ANMR_PREAMBLE_BITS) ?
                        preCnt_q : preCnt_q + 6'h01;
          else
          begin
            preCnt_q <= 6'h00;
            if (preCnt_q == `ANMR_PREAMBLE_BITS)
              state_q <= MdHeader;
          end
        end
        MdHeader:
          if (hdrDone)
          begin
            state_q <= frameOk ? MdTurn : MdPreamble;
            bitCnt_q <= 5'h00;
            isRead_q <= hdrRead;
            hit_q <= frameOk;
            regAddr_q <= hdrReg;
            rdShift_q <= anmr_read(hdrReg);
          end
        MdTurn:
          if (bitCnt_q == 5'h01)
          begin
            state_q <= MdData;
            bitCnt_q <= 5'h00;
            if (isRead_q)
            begin
              mdioOut_q <= rdShift_q[15];
              rdShift_q <= {rdShift_q[14:0], 1'b0};
            end
          end
          else if (isRead_q)
          begin
            mdioOe_q <= 1'b1;
            mdioOut_q <= 1'b0;
          end
        MdData:
          if (dataDone)
          begin
            state_q <= MdPreamble;
            mdioOe_q <= 1'b0;
            mdioOut_q <= 1'b1;
          end
          else if (isRead_q)
          begin
            mdioOut_q <= rdShift_q[15];
            rdShift_q <= {rdShift_q[14:0], 1'b0};
          end
        default: state_q <= MdPreamble;
      endcase
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      txPage_q <= `ANMR_NP_TX_RESET;
      rxPage_q <= `ANMR_NP_RX_RESET;
      pageRcvd_q <= 1'b0;
      intEn_q <= `ANMR_IRQ_EN_RESET;
      intStatus_q <= 1'b0;
      controlWrite_q <= 1'b0;
      controlWrData_q <= 16'h0000;
    end
    else
    begin
      txPage_q <= txPageT_d;
      if (rxPageValid)
        rxPage_q <= rxPage_d;
      pageRcvd_q <= pageRcvd_d;
      intEn_q <= intEn_d;
      intStatus_q <= intStatus_d;
      controlWrite_q <= wrCtl;
      if (wrCtl)
        controlWrData_q <= wrData;
    end
  end
  assign mdioOut = mdioOut_q;
  assign mdioOe = mdioOe_q;
  assign txPage = txPage_q;
  assign autoneg_done_irq = intStatus_q;
  assign controlWrite = controlWrite_q;
  assign controlWrData = controlWrData_q;
  property p_tx_reset;
    @(posedge core_clk) rst |=> (txPage_q == `ANMR_NP_TX_RESET);
  endproperty
  a_tx_reset: assert property (p_tx_reset)
    else $error("transmit page reset value wrong");
  property p_tx_write;
    @(posedge core_clk) disable iff (rst)
    (wrTx && !txPageSent) |=> (txPage_q[15] == $past(wrData[15])) &&
      (txPage_q[13:12] == $past(wrData[13:12])) &&
      (txPage_q[10:0] == $past(wrData[10:0])) && !txPage_q[14];
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("transmit page write not stored");
  property p_toggle;
    @(posedge core_clk) disable iff (rst)
    txPageSent |=> (txPage_q[11] != $past(txPage_q[11]));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle did not flip");
  property p_rx_ack;
    @(posedge core_clk) disable iff (rst)
    rxPageValid |=> rxPage_q[14] && pageRcvd_q;
  endproperty
  a_rx_ack: assert property (p_rx_ack)
    else $error("received page not flagged");
  property p_ext_status;
    @(posedge core_clk) disable iff (rst)
    (rdCommit && (hdrReg == `ANMR_OFS_EXT_STATUS)) |=>
      (rdShift_q == `ANMR_EXT_STATUS_VALUE);
  endproperty
  a_ext_status: assert property (p_ext_status)
    else $error("extended status wrong");
  sequence s_irq_set;
    intEn_q && anDone && !(wrIrq && !wrData[0]);
  endsequence
  property p_irq_set;
    @(posedge core_clk) disable iff (rst)
    s_irq_set |=> autoneg_done_irq ##1 (autoneg_done_irq || wrIrq ||
      $past(wrIrq));
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("interrupt not raised on completion");
  property p_irq_gate;
    @(posedge core_clk) disable iff (rst) !intEn_q |-> !autoneg_done_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt set while disabled");
  property p_no_an_map;
    @(posedge core_clk) disable iff (rst)
    !AUTONEG |-> (anmr_read(`ANMR_OFS_NP_TX) == 16'h0000);
  endproperty
  a_no_an_map: assert property (p_no_an_map)
    else $error("unimplemented register reads nonzero");
  property p_page_clear;
    @(posedge core_clk) disable iff (rst)
    (rdExp && !rxPageValid) |=> !pageRcvd_q;
  endproperty
  a_page_clear: assert property (p_page_clear)
    else $error("page received flag not cleared by read");
endmodule

/* File: rtl/anmr_regs_map.svh */
// register offsets, field positions, reset values and frame counts
`ifndef ANMR_REGS_MAP_SVH
`define ANMR_REGS_MAP_SVH
`define ANMR_OFS_CONTROL 5'h00
`define ANMR_OFS_STATUS 5'h01
`define ANMR_OFS_ID_HI 5'h02
`define ANMR_OFS_ID_LO 5'h03
`define ANMR_OFS_EXPANSION 5'h06
`define ANMR_OFS_NP_TX 5'h07
`define ANMR_OFS_NP_RX 5'h08
`define ANMR_OFS_EXT_STATUS 5'h0f
`define ANMR_OFS_AN_IRQ 5'h10
`define ANMR_NP_MORE_BIT 15
`define ANMR_NP_ACK_BIT 14
`define ANMR_NP_MSG_BIT 13
`define ANMR_NP_ACK2_BIT 12
`define ANMR_NP_TOGGLE_BIT 11
`define ANMR_NP_CODE_MSB 10
`define ANMR_NP_TX_RESET 16'h2001
`define ANMR_NP_RX_RESET 16'h0000
`define ANMR_EXT_STATUS_VALUE 16'h8000
`define ANMR_EXP_NP_ABLE_BIT 2
`define ANMR_EXP_PAGE_RCVD_BIT 1
`define ANMR_IRQ_STATUS_BIT 1
`define ANMR_IRQ_ENABLE_BIT 0
`define ANMR_IRQ_EN_RESET 1'b1
`define ANMR_PREAMBLE_BITS 6'h20
`define ANMR_HDR_BITS 5'h0d
`define ANMR_DATA_BITS 5'h10
`endif

/* File: tb/anmr_sta_model.sv */
// station management controller model that runs serial register frames
`timescale 1ns/1ps
module anmr_sta_model
  import anmr_pkg::*;
(
  input wire logic core_clk,
  input wire logic mdioWire,
  output logic mdc,
  output logic sOut,
  output logic sOe,
  output logic rdDone,
  output anmr_word_t rdData
);
  initial
  begin
    mdc = 1'b0;
    sOut = 1'b1;
    sOe = 1'b0;
    rdDone = 1'b0;
    rdData = 16'h0000;
  end
  // one bit period: four core cycles low, rise with sample, four high
  task automatic bitx(input logic b, input logic drv, output logic s);
    sOut <= b;
    sOe <= drv;
    mdc <= 1'b0;
    repeat (4) @(posedge core_clk);
    s = mdioWire;
    mdc <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic xfer(input logic [4:0] pa, input logic rd,
                      input logic [4:0] ra, input anmr_word_t wd);
    logic [45:0] hdr;
    logic [17:0] tail;
    logic [17:0] acc;
    logic s;
    hdr = {32'hffffffff, 2'b01, rd, ~rd, pa, ra};
    tail = {2'b10, wd};
    acc = 18'h00000;
    for (int i = 45; i >= 0; i--)
      bitx(hdr[i], 1'b1, s);
    for (int i = 17; i >= 0; i--)
    begin
      bitx(tail[i], ~rd, s);
      acc = {acc[16:0], s};
    end
    // clock stands still low and the line is released between frames
    mdc <= 1'b0;
    sOe <= 1'b0;
    sOut <= 1'b1;
    rdData <= acc[15:0];
    rdDone <= rd;
    @(posedge core_clk);
    rdDone <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

/* File: tb/tb.sv */
// bench for the management register bank, full and reduced maps
`timescale 1ns/1ps
module tb
  import anmr_pkg::*;
;
  localparam logic [4:0] PA = 5'h03;
  localparam logic [4:0] PR = 5'h05;
  logic core_clk, rst, mOut, mOe, rOut, rOe, sOut, sOe, mdc, rdDone;
  logic controlWrite, irq, irqR, tgl;
  logic [2:0] evt;
  logic [31:0] seed;
  logic [4:0] redOfs [5] = '{5'h02, 5'h06, 5'h07, 5'h08, 5'h10};
  anmr_word_t controlValue, statusValue, rxPage, controlWrData, txPage;
  anmr_word_t rdData, ex;
  anmr_word_t expQ[$];
  int mismatches = 0;
  int nCompared = 0;
  int cwCount = 0;
  // pulled-up shared line
  wire mdioWire = mOe ? mOut : (rOe ? rOut : (sOe ? sOut : 1'b1));
  anmr_regs dut_u (.core_clk(core_clk), .rst(rst), .phyAddr(PA),
    .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mOut), .mdioOe(mOe),
    .controlValue(controlValue), .statusValue(statusValue),
    .controlWrite(controlWrite), .controlWrData(controlWrData),
    .anComplete(evt[0]), .rxPageValid(evt[1]), .rxPage(rxPage),
    .txPageSent(evt[2]), .txPage(txPage), .autoneg_done_irq(irq));
  anmr_regs #(.AUTONEG(1'b0)) dut_r_u (.core_clk(core_clk), .rst(rst),
    .phyAddr(PR), .mdc(mdc), .mdioIn(mdioWire), .mdioOut(rOut),
    .mdioOe(rOe), .controlValue(controlValue), .statusValue(statusValue),
    .controlWrite(), .controlWrData(), .anComplete(evt[0]),
    .rxPageValid(evt[1]), .rxPage(rxPage), .txPageSent(evt[2]),
    .txPage(), .autoneg_done_irq(irqR));
  anmr_sta_model sta_u (.core_clk(core_clk), .mdioWire(mdioWire),
    .mdc(mdc), .sOut(sOut), .sOe(sOe), .rdDone(rdDone), .rdData(rdData));
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    logic [31:0] v;
    v = s;
    for (int i = 0; i < 16; i++)
      v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction
  task automatic check(input anmr_word_t seen, input anmr_word_t exp);
    nCompared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [4:0] pa, ra, input anmr_word_t exp);
    expQ.push_back(exp);
    sta_u.xfer(pa, 1'b1, ra, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] pa, ra, input anmr_word_t d);
    sta_u.xfer(pa, 1'b0, ra, d);
  endtask
  task automatic ev(input logic [2:0] m);
    evt <= m;
    @(posedge core_clk);
    evt <= 3'h0;
    repeat (2) @(posedge core_clk);
  endtask
  task report_and_stop;
    if (mismatches == 0 && nCompared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (controlWrite === 1'b1)
      cwCount++;
  always @(posedge core_clk)
    if (rdDone === 1'b1)
      check(rdData, expQ.pop_front());
  initial
  begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    rst = 1'b1;
    evt = 3'h0;
    controlValue = 16'h0000;
    statusValue = 16'h0000;
    rxPage = 16'h0000;
    seed = 32'h62c9;
    tgl = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(PA, 5'h07, 16'h2001);
    rd(PA, 5'h08, 16'h0000);
    rd(PA, 5'h0f, 16'h8000);
    rd(PA, 5'h10, 16'h0001);
    rd(PA, 5'h06, 16'h0004);
    rd(PA, 5'h1f, 16'h0000);
    check(txPage, 16'h2001);
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr_step(seed);
      rxPage <= seed[31:16];
      ev(3'h2);
      rd(PA, 5'h08, seed[31:16] | 16'h4000);
      rd(PA, 5'h06, 16'h0006);
      rd(PA, 5'h06, 16'h0004);
      // next page loaded only once the partner page was taken
      wr(PA, 5'h07, seed[15:0]);
      ex = (seed[15:0] & 16'hb7ff) | {4'h0, tgl, 11'h000};
      rd(PA, 5'h07, ex);
      check(txPage, ex);
      ev(3'h4);
      tgl = ~tgl;
      rd(PA, 5'h07, ex ^ 16'h0800);
    end
    wr(PA, 5'h08, 16'hffff);
    wr(PA, 5'h0f, 16'h0000);
    wr(5'h09, 5'h07, 16'h0000);
    rd(PA, 5'h08, rxPage | 16'h4000);
    rd(PA, 5'h0f, 16'h8000);
    rd(PA, 5'h07, ex ^ 16'h0800);
    controlValue <= seed[15:0];
    statusValue <= seed[31:16];
    rd(PA, 5'h00, seed[15:0]);
    rd(PA, 5'h01, seed[31:16]);
    wr(PA, 5'h00, ~seed[15:0]);
    check(controlWrData, ~seed[15:0]);
    check(16'(cwCount), 16'h0001);
    ev(3'h1);
    check({15'h0000, irq}, 16'h0001);
    rd(PA, 5'h10, 16'h0003);
    wr(PA, 5'h10, 16'h0001);
    check({15'h0000, irq}, 16'h0000);
    ev(3'h1);
    wr(PA, 5'h10, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    ev(3'h1);
    rd(PA, 5'h10, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    wr(PR, 5'h10, 16'hffff);
    wr(PR, 5'h0f, 16'h0000);
    foreach (redOfs[i])
      rd(PR, redOfs[i], 16'h0000);
    rd(PR, 5'h0f, 16'h8000);
    rd(PR, 5'h00, seed[15:0]);
    check({15'h0000, irqR}, 16'h0000);
    report_and_stop();
  end
endmodule
